// ### csfr_alu.sv
// Result and flag computation for one executed operation.
module csfr_alu
  import csfr_pkg::*;
(
  input wire csfr_op_type op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [7:0] flags,
  output logic [7:0] result,
  output logic [7:0] new_flags,
  output logic [7:0] affect,
  output logic writes_back
);

  logic [8:0] sum;
  logic [4:0] half;
  logic cin;
  logic zs;
  logic [7:0] corr;

  always_comb begin
    cin = 1'b0;
    sum = 9'h000;
    half = 5'h00;
    corr = 8'h00;
    zs = 1'b1;
    result = a;
    new_flags = flags;
    affect = MASK_ZSV;
    writes_back = 1'b1;
    case (op)
      OP_ADD, OP_ADC: begin
        cin = (op == OP_ADC) & flags[FLAG_C];
        sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        result = sum[7:0];
        new_flags[FLAG_C] = sum[8];
        new_flags[FLAG_V] = (a[7] == b[7]) && (sum[7] != a[7]);
        new_flags[FLAG_D] = 1'b0;
        new_flags[FLAG_H] = half[4];
        affect = MASK_ARITH_BCD;
      end
      OP_SUB, OP_SBC, OP_CP: begin
        cin = (op == OP_SBC) & flags[FLAG_C];
        sum = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        result = sum[7:0];
        new_flags[FLAG_C] = sum[8];
        new_flags[FLAG_V] = (a[7] != b[7]) && (sum[7] != a[7]);
        new_flags[FLAG_D] = 1'b1;
        new_flags[FLAG_H] = half[4];
        affect = (op == OP_CP) ? MASK_ARITH : MASK_ARITH_BCD;
        writes_back = (op != OP_CP);
      end
      OP_INC, OP_DEC: begin
        result = (op == OP_INC) ? a + 8'h01 : a - 8'h01;
        new_flags[FLAG_V] = (result[7] != a[7]) && (a[7] == (op == OP_DEC));
      end
      OP_AND, OP_OR, OP_XOR, OP_COM, OP_TM: begin
        case (op)
          OP_OR: result = a | b;
          OP_XOR: result = a ^ b;
          OP_COM: result = ~a;
          default: result = a & b;
        endcase
        new_flags[FLAG_V] = 1'b0;
        writes_back = (op != OP_TM);
      end
      OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SRA: begin
        case (op)
          OP_RL: result = {a[6:0], a[7]};
          OP_RLC: result = {a[6:0], flags[FLAG_C]};
          OP_RR: result = {a[0], a[7:1]};
          OP_RRC: result = {flags[FLAG_C], a[7:1]};
          default: result = {a[7], a[7:1]};
        endcase
        new_flags[FLAG_C] = (op == OP_RL || op == OP_RLC) ? a[7] : a[0];
        new_flags[FLAG_V] = (op != OP_SRA) && (result[7] != a[7]);
        affect = MASK_ARITH;
      end
      OP_DA: begin
        if (!flags[FLAG_D]) begin
          corr = ((flags[FLAG_H] || a[3:0] > BCD_DIGIT_MAX) ? BCD_LOW_FIX : 8'h00) |
                 ((flags[FLAG_C] || a > BCD_BYTE_MAX) ? BCD_HIGH_FIX : 8'h00);
          result = a + corr;
          new_flags[FLAG_C] = flags[FLAG_C] || (a > BCD_BYTE_MAX);
        end else begin
          corr = (flags[FLAG_H] ? BCD_LOW_FIX : 8'h00) | (flags[FLAG_C] ? BCD_HIGH_FIX : 8'h00);
          result = a - corr;
        end
        affect = MASK_ARITH;
      end
      default: begin
        zs = 1'b0;
        writes_back = 1'b0;
        affect = 8'h00;
        case (op)
          OP_SCF, OP_RCF, OP_CCF: begin
            new_flags[FLAG_C] = (op == OP_SCF) | ((op == OP_CCF) & ~flags[FLAG_C]);
            affect[FLAG_C] = 1'b1;
          end
          OP_SB0, OP_SB1: begin
            new_flags[FLAG_BA] = (op == OP_SB1);
            affect[FLAG_BA] = 1'b1;
          end
          OP_INTERRUPT_RETURN_INSTR: begin
            new_flags[FLAG_FIS] = 1'b0;
            affect[FLAG_FIS] = 1'b1;
          end
          OP_LDF: begin
            new_flags = a;
            affect = MASK_ALL;
          end
          default: affect = 8'h00;
        endcase
      end
    endcase
    if (zs) begin
      new_flags[FLAG_Z] = (result == 8'h00);
      new_flags[FLAG_S] = result[7];
    end
  end

endmodule

// ### csfr_cond.sv
// Condition-code evaluation for conditional jumps from the four testable flags.
module csfr_cond
  import csfr_pkg::*;
(
  input wire logic [3:0] cc,
  input wire logic [7:0] flags,
  output logic taken
);

  logic base;

  // The top code bit inverts the sense of the lower three.
  always_comb begin
    case (cc[2:0])
      3'h0: base = 1'b0;
      3'h1: base = flags[FLAG_S] ^ flags[FLAG_V];
      3'h2: base = flags[FLAG_Z] | (flags[FLAG_S] ^ flags[FLAG_V]);
      3'h3: base = flags[FLAG_C] | flags[FLAG_Z];
      3'h4: base = flags[FLAG_V];
      3'h5: base = flags[FLAG_S];
      3'h6: base = flags[FLAG_Z];
      default: base = flags[FLAG_C];
    endcase
    taken = base ^ cc[3];
  end

endmodule

// ### csfr_core.sv
// Status flags register with APB access, flag update, jump conditions and operand checks.
// Operation
// - Carry, zero, sign, overflow feed jump tests; decimal and half-carry serve BCD only.
// - Carry set on carry out of or borrow into bit 7.
// - After rotate or shift, carry holds the last bit shifted out.
// - Instructions can set, clear or invert the carry bit.
// - Zero bit set when an arithmetic or logic result is all zero.
// - Zero bit set when bit-test, shift or rotate result is zero.
// - Sign bit copies the result's most significant bit.
// - Overflow set when the signed result leaves -128 to +127.
// - Logic operations clear the overflow bit.
// - Decimal bit records add or subtract; never a jump condition.
// - Half-carry on carry out of bit 3 or borrow out of bit 4.
// - Decimal adjust uses half-carry to correct the result into BCD.
// - Fast-interrupt bit set on fast interrupt start, cleared by interrupt return.
// - Fast-interrupt bit blocks interrupts and selects the fast return sequence.
// - Bank bit selects set 1 bank; bank-0 instruction clears, bank-1 sets it.
// - The flags register may be written directly by non-flag instructions.
// - Bitwise AND updates zero and sign from its result and clears overflow.
// - Simultaneous flag update and direct write give an unspecified result.
// - Register pairs are even numbers 0 to 254 or working pairs 0 to 14.
// - Relative displacement is signed -128..+127 added to the next address.
// - Working registers select one of sixteen; bit operands select 0 to 7.
// - Carry, zero, sign and overflow drive four-bit condition evaluation.
module csfr_core
  import csfr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic exec_valid,
  input wire csfr_op_type exec_op,
  input wire logic [7:0] exec_a,
  input wire logic [7:0] exec_b,
  output logic [7:0] exec_result,
  output logic [7:0] flags_out,
  input wire logic fast_irq_start,
  input wire logic irq_request,
  output logic irq_grant,
  output logic fast_return,
  output logic bank_select,
  input wire logic [3:0] jump_cc,
  output logic jump_taken,
  input wire logic [7:0] pair_index,
  input wire logic pair_is_working,
  output logic pair_ok,
  input wire logic [15:0] next_pc,
  input wire logic [7:0] displacement,
  output logic [15:0] branch_target,
  input wire logic [3:0] work_sel,
  input wire logic [2:0] bit_sel,
  output logic [15:0] work_onehot,
  output logic [7:0] bit_mask
);

  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [7:0] alu_result;
  logic [7:0] alu_flags;
  logic [7:0] alu_affect;
  logic alu_writes;
  logic apb_setup;
  logic apb_access;
  logic addr_flags;
  logic addr_result;
  logic [31:0] next_prdata;
  logic next_pair_ok;

  csfr_alu u_alu (
    .op(exec_op),
    .a(exec_a),
    .b(exec_b),
    .flags(flags),
    .result(alu_result),
    .new_flags(alu_flags),
    .affect(alu_affect),
    .writes_back(alu_writes)
  );

  csfr_cond u_cond (
    .cc(jump_cc),
    .flags(flags),
    .taken(jump_taken)
  );

  // Bus decode; data is staged in the setup cycle so the access phase needs no wait.
  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  assign addr_flags = (paddr == FLAGS_ADDR);
  assign addr_result = (paddr == RESULT_ADDR);
  assign pready = 1'b1;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (addr_flags) begin
      next_prdata[7:0] = flags;
    end else if (addr_result) begin
      next_prdata[7:0] = exec_result;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= ~(addr_flags | addr_result);
    end
  end

  // A direct write lands first; an executing instruction then overrides only the bits it affects.
  always_comb begin
    next_flags = flags;
    if (apb_access && pwrite && addr_flags) begin
      next_flags = pwdata[7:0];
    end
    if (exec_valid) begin
      next_flags = (next_flags & ~alu_affect) | (alu_flags & alu_affect);
    end
    if (fast_irq_start) begin
      next_flags[FLAG_FIS] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= FLAGS_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_result <= 8'h00;
    end else if (exec_valid && alu_writes) begin
      exec_result <= alu_result;
    end
  end

  assign flags_out = flags;
  assign bank_select = flags[FLAG_BA];
  assign irq_grant = irq_request & ~flags[FLAG_FIS];
  assign fast_return = exec_valid & (exec_op == OP_INTERRUPT_RETURN_INSTR) & flags[FLAG_FIS];

  // Operand range checks and decodes for instruction decode.
  always_comb begin
    if (pair_is_working) begin
      next_pair_ok = ~pair_index[0] && (pair_index[3:0] <= WORK_PAIR_MAX) && (pair_index[7:4] == 4'h0);
    end else begin
      next_pair_ok = ~pair_index[0] && (pair_index <= RR_MAX);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_ok <= 1'b0;
      branch_target <= 16'h0000;
    end else begin
      pair_ok <= next_pair_ok;
      branch_target <= next_pc + {{8{displacement[7]}}, displacement};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_work
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          work_onehot[gi] <= 1'b0;
        end else begin
          work_onehot[gi] <= (work_sel == 4'(gi));
        end
      end
      if (gi < 8) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            bit_mask[gi] <= 1'b0;
          end else begin
            bit_mask[gi] <= (bit_sel == 3'(gi));
          end
        end
      end
    end
  endgenerate

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_op(csfr_op_type o);
    exec_valid && exec_op == o && !fast_irq_start;
  endsequence

  sequence s_quiet;
    !exec_valid && !fast_irq_start && !(apb_access && pwrite);
  endsequence

  chk_carry_set: assert property (s_op(OP_SCF) |=> flags[FLAG_C])
    else $error("carry not set by set-carry");
  chk_carry_invert: assert property (s_op(OP_CCF) |=> flags[FLAG_C] != $past(flags[FLAG_C]))
    else $error("carry not inverted");
  chk_bank_select: assert property (s_op(OP_SB1) ##1 s_op(OP_SB0) |-> bank_select ##1 !bank_select)
    else $error("bank bit does not follow bank instructions");
  chk_fis_set: assert property (fast_irq_start |=> flags[FLAG_FIS] && !irq_grant)
    else $error("fast interrupt bit not set or interrupts not blocked");
  chk_fis_return: assert property (s_op(OP_INTERRUPT_RETURN_INSTR) and flags[FLAG_FIS] |-> fast_return ##1 !flags[FLAG_FIS])
    else $error("interrupt return did not end fast servicing");
  chk_logic_ovf: assert property (s_op(OP_AND) |=> !flags[FLAG_V] && flags[FLAG_Z] == (exec_result == 8'h00))
    else $error("logic operation flags wrong");
  chk_add_flags: assert property (s_op(OP_ADD) |=> flags[FLAG_S] == exec_result[7]
      && flags[FLAG_C] == ($past({1'b0, exec_a}) + $past({1'b0, exec_b}) > 9'h0FF))
    else $error("add carry or sign wrong");
  chk_shift_carry: assert property (s_op(OP_RR) |=> flags[FLAG_C] == $past(exec_a[0]))
    else $error("rotate carry is not the bit shifted out");
  chk_keep_flags: assert property (s_op(OP_SB1) or s_quiet |=> flags[7:1] == $past(flags[7:1]))
    else $error("unaffected flags changed");
  chk_cond_jump: assert property (jump_cc == CC_CARRY |-> jump_taken == flags[FLAG_C])
    else $error("carry condition mismatch");
  chk_pair_even: assert property (pair_ok |-> !$past(pair_index[0]))
    else $error("odd register pair accepted");
  chk_branch_target: assert property (##1 branch_target == $past(next_pc) + {{8{$past(displacement[7])}}, $past(displacement)})
    else $error("branch target wrong");
  chk_sub_borrow: assert property (s_op(OP_SUB) |=> flags[FLAG_D]
      && flags[FLAG_C] == ($past(exec_b) > $past(exec_a)))
    else $error("subtract borrow or decimal bit wrong");
  chk_add_half: assert property (s_op(OP_ADD) |=> !flags[FLAG_D]
      && flags[FLAG_H] == (exec_result[3:0] < $past(exec_a[3:0])))
    else $error("add half-carry or decimal bit wrong");
  chk_add_ovf: assert property (s_op(OP_ADD) |=> flags[FLAG_V] == ($past(exec_a[7]) == $past(exec_b[7])
      && exec_result[7] != $past(exec_a[7])))
    else $error("add overflow wrong");
  chk_or_flags: assert property (s_op(OP_OR) |=> !flags[FLAG_V] && flags[FLAG_Z] == (exec_result == 8'h00))
    else $error("logic zero or overflow wrong");
  chk_test_zero: assert property (s_op(OP_TM) |=>
      flags[FLAG_Z] == (($past(exec_a) & $past(exec_b)) == 8'h00))
    else $error("bit test zero flag wrong");
  chk_carry_clear: assert property (s_op(OP_RCF) |=> !flags[FLAG_C])
    else $error("carry not cleared");
  chk_direct_write: assert property (apb_access && pwrite && addr_flags && !exec_valid && !fast_irq_start
      |=> flags == $past(pwdata[7:0]))
    else $error("direct write did not land");
  chk_da_sub: assert property (s_op(OP_DA) and flags[FLAG_D] |=> exec_result == $past(exec_a)
      - ($past(flags[FLAG_H]) ? BCD_LOW_FIX : 8'h00) - ($past(flags[FLAG_C]) ? BCD_HIGH_FIX : 8'h00))
    else $error("decimal adjust after subtract wrong");
  chk_cond_zero: assert property (jump_cc == CC_ZERO |-> jump_taken == flags[FLAG_Z])
    else $error("zero condition mismatch");
  chk_cond_sign: assert property (jump_cc == CC_MINUS |-> jump_taken == flags[FLAG_S])
    else $error("minus condition mismatch");
  chk_cond_ovf: assert property (jump_cc == CC_OVERFLOW |-> jump_taken == flags[FLAG_V])
    else $error("overflow condition mismatch");
  chk_work_decode: assert property (presetn |=> work_onehot == (16'h0001 << $past(work_sel)))
    else $error("working register decode wrong");
  chk_bit_decode: assert property (presetn |=> bit_mask == (8'h01 << $past(bit_sel)))
    else $error("bit position decode wrong");

endmodule

// ### csfr_pkg.sv
// Package of constants and types shared by the status flags register block.
package csfr_pkg;

  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam int FLAG_D = 3;
  localparam int FLAG_H = 2;
  localparam int FLAG_FIS = 1;
  localparam int FLAG_BA = 0;

  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] FLAGS_INDEX = 8'hD5;
  localparam logic [7:0] RESULT_INDEX = 8'hD6;
  localparam logic [9:0] FLAGS_ADDR = {FLAGS_INDEX, 2'h0};
  localparam logic [9:0] RESULT_ADDR = {RESULT_INDEX, 2'h0};

  // Which flag bits each class of operation is allowed to change.
  localparam logic [7:0] MASK_ARITH_BCD = 8'hFC;
  localparam logic [7:0] MASK_ARITH = 8'hF0;
  localparam logic [7:0] MASK_ZSV = 8'h70;
  localparam logic [7:0] MASK_ALL = 8'hFF;

  localparam logic [7:0] RR_MAX = 8'hFE;
  localparam logic [3:0] WORK_PAIR_MAX = 4'hE;
  localparam logic [3:0] CC_CARRY = 4'h7;
  localparam logic [3:0] CC_ZERO = 4'h6;
  localparam logic [3:0] CC_MINUS = 4'h5;
  localparam logic [3:0] CC_OVERFLOW = 4'h4;

  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;

  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CP, OP_INC, OP_DEC,
    OP_AND, OP_OR, OP_XOR, OP_COM, OP_TM, OP_RL, OP_RLC, OP_RR,
    OP_RRC, OP_SRA, OP_DA, OP_SCF, OP_RCF, OP_CCF, OP_SB0, OP_SB1,
    OP_INTERRUPT_RETURN_INSTR, OP_LDF
  } csfr_op_type;

endpackage

// ### tb_top.sv
// Self-checking testbench for the status flags register block.
module tb_top
  import csfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic exec_valid = 1'b0;
  csfr_op_type exec_op = OP_NOP;
  logic [7:0] exec_a = 8'h00;
  logic [7:0] exec_b = 8'h00;
  logic [7:0] exec_result;
  logic [7:0] flags_out;
  logic fast_irq_start = 1'b0;
  logic irq_request = 1'b0;
  logic irq_grant;
  logic fast_return;
  logic bank_select;
  logic [3:0] jump_cc = 4'h0;
  logic jump_taken;
  logic [7:0] pair_index = 8'h00;
  logic pair_is_working = 1'b0;
  logic pair_ok;
  logic [15:0] next_pc = 16'h0000;
  logic [7:0] displacement = 8'h00;
  logic [15:0] branch_target;
  logic [3:0] work_sel = 4'h0;
  logic [2:0] bit_sel = 3'h0;
  logic [15:0] work_onehot;
  logic [7:0] bit_mask;

  int err_total = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h2F9B;
  logic [7:0] fl = 8'h00;
  logic [7:0] lr = 8'h00;
  logic ex_seen = 1'b0;
  logic [15:0] exp_ex[$];
  logic [32:0] exp_rd[$];
  csfr_op_type ops[20] = '{OP_ADD, OP_ADC, OP_SUB, OP_SBC, OP_CP, OP_AND, OP_OR, OP_XOR, OP_RL, OP_RLC,
                           OP_RR, OP_RRC, OP_SRA, OP_CCF, OP_NOP, OP_INC, OP_DEC, OP_COM, OP_TM, OP_DA};

  csfr_core i_csfr_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .exec_valid(exec_valid), .exec_op(exec_op), .exec_a(exec_a), .exec_b(exec_b), .exec_result(exec_result),
    .flags_out(flags_out), .fast_irq_start(fast_irq_start), .irq_request(irq_request), .irq_grant(irq_grant),
    .fast_return(fast_return), .bank_select(bank_select), .jump_cc(jump_cc), .jump_taken(jump_taken),
    .pair_index(pair_index), .pair_is_working(pair_is_working), .pair_ok(pair_ok), .next_pc(next_pc),
    .displacement(displacement), .branch_target(branch_target), .work_sel(work_sel), .bit_sel(bit_sel),
    .work_onehot(work_onehot), .bit_mask(bit_mask));

  always #20 pclk = ~pclk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Reference flag model; it runs in step with every issued instruction.
  task automatic model(input csfr_op_type op, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic c;
    logic ci;
    logic wb;
    c = fl[FLAG_C];
    ci = (op == OP_ADC || op == OP_SBC) ? c : 1'b0;
    wb = 1'b1;
    r = a;
    case (op)
      OP_ADD, OP_ADC: begin
        s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        r = s[7:0];
        fl[FLAG_C] = s[8];
        fl[FLAG_V] = (a[7] == b[7]) && (r[7] != a[7]);
        fl[FLAG_D] = 1'b0;
        fl[FLAG_H] = h[4];
      end
      OP_SUB, OP_SBC, OP_CP: begin
        s = {1'b0, a} - {1'b0, b} - {8'h00, ci};
        h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ci};
        r = s[7:0];
        fl[FLAG_C] = s[8];
        fl[FLAG_V] = (a[7] != b[7]) && (r[7] != a[7]);
        if (op == OP_CP) wb = 1'b0;
        else begin
          fl[FLAG_D] = 1'b1;
          fl[FLAG_H] = h[4];
        end
      end
      OP_INC, OP_DEC: begin
        r = (op == OP_INC) ? a + 8'h01 : a - 8'h01;
        fl[FLAG_V] = (op == OP_INC) ? (a == 8'h7F) : (a == 8'h80);
      end
      OP_AND, OP_OR, OP_XOR, OP_COM, OP_TM: begin
        r = (op == OP_OR) ? (a | b) : (op == OP_XOR) ? (a ^ b) : (op == OP_COM) ? ~a : (a & b);
        fl[FLAG_V] = 1'b0;
        if (op == OP_TM) wb = 1'b0;
      end
      OP_DA: begin
        if (!fl[FLAG_D]) begin
          r = a + ((fl[FLAG_H] || a[3:0] > 4'h9) ? 8'h06 : 8'h00) + ((c || a > 8'h99) ? 8'h60 : 8'h00);
          fl[FLAG_C] = c || (a > 8'h99);
        end else begin
          r = a - (fl[FLAG_H] ? 8'h06 : 8'h00) - (c ? 8'h60 : 8'h00);
        end
      end
      OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SRA: begin
        if (op == OP_RL || op == OP_RLC) r = {a[6:0], (op == OP_RL) ? a[7] : c};
        else r = {(op == OP_RR) ? a[0] : (op == OP_RRC) ? c : a[7], a[7:1]};
        fl[FLAG_C] = (op == OP_RL || op == OP_RLC) ? a[7] : a[0];
        fl[FLAG_V] = (op == OP_SRA) ? 1'b0 : (a[7] ^ r[7]);
      end
      default: begin
        wb = 1'b0;
        if (op == OP_SCF) fl[FLAG_C] = 1'b1;
        if (op == OP_RCF) fl[FLAG_C] = 1'b0;
        if (op == OP_CCF) fl[FLAG_C] = ~c;
        if (op == OP_SB0 || op == OP_SB1) fl[FLAG_BA] = (op == OP_SB1);
        if (op == OP_INTERRUPT_RETURN_INSTR) fl[FLAG_FIS] = 1'b0;
        if (op == OP_LDF) fl = a;
      end
    endcase
    if (wb || op == OP_CP || op == OP_TM) begin
      fl[FLAG_Z] = (r == 8'h00);
      fl[FLAG_S] = r[7];
    end
    if (wb) lr = r;
  endtask

  task automatic exec(input csfr_op_type op, input logic [7:0] a, input logic [7:0] b);
    @(posedge pclk);
    exec_valid <= 1'b1;
    exec_op <= op;
    exec_a <= a;
    exec_b <= b;
    model(op, a, b);
    exp_ex.push_back({lr, fl});
  endtask

  task automatic idle();
    @(posedge pclk);
    exec_valid <= 1'b0;
  endtask

  task automatic apb(input logic wr, input logic [9:0] ad, input logic [31:0] d, input logic [32:0] e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (!wr) exp_rd.push_back(e);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic jexp(input logic [3:0] cc, input logic [7:0] f);
    logic t;
    case (cc[2:0])
      3'h0: t = 1'b0;
      3'h7: t = f[FLAG_C];
      3'h6: t = f[FLAG_Z];
      3'h5: t = f[FLAG_S];
      3'h4: t = f[FLAG_V];
      3'h1: t = f[FLAG_S] ^ f[FLAG_V];
      3'h2: t = f[FLAG_Z] | (f[FLAG_S] ^ f[FLAG_V]);
      default: t = f[FLAG_C] | f[FLAG_Z];
    endcase
    return t ^ cc[3];
  endfunction

  // Result watcher: exec results show one edge after issue, reads at the access edge.
  always @(posedge pclk) begin
    ex_seen <= exec_valid;
    if (ex_seen && exp_ex.size() > 0) check("flags_result", {17'h0, exec_result, flags_out}, {17'h0, exp_ex.pop_front()});
    if (psel && penable && pready && !pwrite && exp_rd.size() > 0) check("apb_read", {pslverr, prdata}, exp_rd.pop_front());
  end

  initial begin
    #(40 * 20000);
    err_total++;
    finish_test();
  end

  initial begin
    logic [31:0] v;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FLAGS_ADDR, 32'h0, {1'b0, 24'h0, FLAGS_RESET});
    apb(1'b1, FLAGS_ADDR, 32'hDEAD00A5, 33'h0);
    fl = 8'hA5;
    apb(1'b0, FLAGS_ADDR, 32'h0, 33'h0000000A5);
    apb(1'b1, RESULT_ADDR, 32'h000000FF, 33'h0);
    apb(1'b0, RESULT_ADDR, 32'h0, 33'h0);
    apb(1'b0, 10'h100, 32'h0, 33'h100000000);
    apb(1'b0, FLAGS_ADDR + 10'h001, 32'h0, 33'h100000000);
    exec(OP_ADD, 8'h7F, 8'h01);
    exec(OP_ADD, 8'hFF, 8'h01);
    exec(OP_SUB, 8'h00, 8'h01);
    exec(OP_SUB, 8'h80, 8'h01);
    exec(OP_AND, 8'hF0, 8'h0F);
    exec(OP_RRC, 8'h01, 8'h00);
    exec(OP_SCF, 8'h00, 8'h00);
    exec(OP_CCF, 8'h00, 8'h00);
    exec(OP_CCF, 8'h00, 8'h00);
    exec(OP_RCF, 8'h00, 8'h00);
    exec(OP_SB1, 8'h00, 8'h00);
    exec(OP_SB0, 8'h00, 8'h00);
    for (int k = 0; k < 300; k++) begin
      v = rnd();
      exec(ops[v[31:16] % 20], v[7:0], v[15:8]);
    end
    idle();
    apb(1'b0, RESULT_ADDR, 32'h0, {25'h0, lr});
    apb(1'b0, FLAGS_ADDR, 32'h0, {25'h0, fl});
    check("bank_select", bank_select, fl[FLAG_BA]);
    exec(OP_INTERRUPT_RETURN_INSTR, 8'h00, 8'h00);
    irq_request <= 1'b1;
    #1 check("fast_return_idle", fast_return, 1'b0);
    idle();
    fast_irq_start <= 1'b1;
    @(posedge pclk);
    fast_irq_start <= 1'b0;
    fl[FLAG_FIS] = 1'b1;
    #1 check("irq_grant_blocked", irq_grant, 1'b0);
    check("fis_set", flags_out, fl);
    exec(OP_INTERRUPT_RETURN_INSTR, 8'h00, 8'h00);
    #1 check("fast_return", fast_return, 1'b1);
    idle();
    #1 check("irq_grant_open", irq_grant, 1'b1);
    for (int k = 0; k < 64; k++) begin
      exec(OP_LDF, 8'(rnd()), 8'h00);
      idle();
      jump_cc <= k[3:0];
      @(negedge pclk);
      check("jump_taken", jump_taken, jexp(k[3:0], fl));
    end
    for (int k = 0; k < 60; k++) begin
      v = rnd();
      @(posedge pclk);
      pair_index <= v[0] ? (v[15:8] & 8'h1F) : v[15:8];
      pair_is_working <= v[0];
      displacement <= v[23:16];
      next_pc <= v[31:16];
      work_sel <= v[4:1];
      bit_sel <= v[7:5];
      @(posedge pclk);
      @(negedge pclk);
      check("pair_ok", pair_ok, !pair_index[0] && (!pair_is_working || pair_index[7:4] == 4'h0));
      check("branch", branch_target, 16'(next_pc + {{8{displacement[7]}}, displacement}));
      check("work_onehot", work_onehot, 16'h0001 << work_sel);
      check("bit_mask", bit_mask, 8'h01 << bit_sel);
    end
    repeat (3) @(posedge pclk);
    check("pending", exp_ex.size() + exp_rd.size(), 0);
    finish_test();
  end
endmodule
